/* File: hw/pwr_pkg.sv */
package pwr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_BRIDGE_PMCSR = 8'h00; // bridge power state, soft reset
    localparam logic [7:0] OFF_LINK_CTRL    = 8'h04; // active-state entry select
    localparam logic [7:0] OFF_LINK_CAP     = 8'h08; // exit latencies, read only
    localparam logic [7:0] OFF_FW_PMCSR     = 8'h0C; // link-controller power state, resets
    localparam logic [7:0] OFF_STATUS       = 8'h10; // link state, init and eeprom busy bits, sticky flags
    localparam logic [7:0] OFF_STICKY       = 8'h14; // sticky scratch, clear-on-write
    localparam logic [7:0] OFF_EELOAD       = 8'h18; // eeprom-loadable bits, set-on-write

    // device power state encoding
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;

    // active-state entry select encoding
    localparam logic [1:0] AS_OFF  = 2'h0;
    localparam logic [1:0] AS_L0S  = 2'h1;
    localparam logic [1:0] AS_L1   = 2'h2;
    localparam logic [1:0] AS_BOTH = 2'h3;

    // field positions
    localparam int FW_BRIDGE_SOFT_RESET_BIT_BIT   = 2;  // link controller reset bit
    localparam int FW_PHYR_BIT   = 3;  // phy reset request bit
    localparam int FW_INIT_BIT   = 4;  // D0 active (1) versus D0 uninitialized (0)
    localparam int BR_BRIDGE_SOFT_RESET_BIT_BIT   = 2;  // bridge soft reset bit
    localparam int L0S_LAT_POS   = 12;
    localparam int L1_LAT_POS    = 15;

    // reset values
    localparam logic [2:0] L0S_EXIT_LAT_RST = 3'h4;
    localparam logic [2:0] L1_EXIT_LAT_RST  = 3'h6;
    localparam logic [7:0] EELOAD_RST       = 8'h00;
    localparam logic [7:0] STICKY_RST       = 8'h00;

    // idle time before active-state entry
    localparam int CLK_MHZ          = 200;
    localparam int L0S_IDLE_NS      = 7000;
    localparam int L1_IDLE_NS       = 10000;
    localparam int L0S_IDLE_CYC     = (L0S_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int L1_IDLE_CYC      = (L1_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int EE_LOAD_CYC      = 64;  // modelled eeprom download length

    typedef enum logic [2:0] {LS_L0, LS_L0S, LS_L1, LS_ASPM_L1, LS_L23} link_state_e;
endpackage

/* File: hw/power_state_reset_control.sv */
`timescale 1ns/1ps
module power_state_reset_control #(
    parameter int L0S_IDLE = pwr_pkg::L0S_IDLE_CYC,
    parameter int L1_IDLE  = pwr_pkg::L1_IDLE_CYC
) (
    // clock and power-on reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // reset pins, asynchronous to hclk
    input  wire logic        global_reset_input_n,
    input  wire logic        fundamental_reset_n,
    input  wire logic        hot_reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link activity from the transaction layer
    input  wire logic        tx_pending,
    input  wire logic        tx_idle,
    input  wire logic        l1_request_rx,
    input  wire logic        aux_power_lost,
    input  wire logic        pme_request,
    // link and clock control
    output logic      [2:0]  link_state,
    output logic             send_aspm_nak,
    output logic             bridge_clk_en,
    output logic             lc_clk_en,
    output logic             dma_link_reset,
    output logic             phy_reset,
    output logic             cfg_reset,
    output logic             eeprom_load_start,
    output logic             pme_out
);
    // reset pins, two-stage synchronisers
    logic [1:0] global_reset_input_sync_reg;
    logic [1:0] perst_sync_reg;
    logic [1:0] hot_sync_reg;
    logic       perst_prev_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            global_reset_input_sync_reg  <= 2'h0;
            perst_sync_reg <= 2'h0;
            hot_sync_reg   <= 2'h0;
            perst_prev_reg <= 1'b0;
        end
        else
        begin
            global_reset_input_sync_reg  <= {global_reset_input_sync_reg[0], global_reset_input_n};
            perst_sync_reg <= {perst_sync_reg[0], fundamental_reset_n};
            hot_sync_reg   <= {hot_sync_reg[0], hot_reset};
            perst_prev_reg <= perst_sync_reg[1];
        end
    end

    // reset classes, each a superset of the one above it
    wire global_reset_input_act     = !global_reset_input_sync_reg[1];
    wire perst_act    = !perst_sync_reg[1];
    wire rst_sticky   = global_reset_input_act;
    wire rst_eeload   = global_reset_input_act || perst_act;
    logic        br_bridge_soft_reset_bit_reg;
    wire rst_ordinary = rst_eeload || hot_sync_reg[1] || br_bridge_soft_reset_bit_reg;
    wire perst_rise   = perst_sync_reg[1] && !perst_prev_reg;

    // bus address phase capture
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    wire         addr_ok = hsel && htrans[1] && hready;
    wire         wr_go   = wr_pend_reg;
    wire [31:0]  wd      = hwdata;

    // registers
    logic [1:0]  br_dstate_reg;
    logic [1:0]  as_sel_reg;
    logic [1:0]  fw_dstate_reg;
    logic        fw_init_reg;
    logic        fw_bridge_soft_reset_bit_reg;
    logic        phyr_reg;
    logic [7:0]  sticky_reg;
    logic [7:0]  eeload_reg;
    logic        nak_flag_reg;
    logic        d3cold_reg;
    logic [7:0]  ee_cnt_reg;
    logic [2:0]  l0s_lat_reg;
    logic [2:0]  l1_lat_reg;

    wire wr_br     = wr_go && (wr_addr_reg == pwr_pkg::OFF_BRIDGE_PMCSR);
    wire wr_lctl   = wr_go && (wr_addr_reg == pwr_pkg::OFF_LINK_CTRL);
    wire wr_fw     = wr_go && (wr_addr_reg == pwr_pkg::OFF_FW_PMCSR);
    wire wr_status = wr_go && (wr_addr_reg == pwr_pkg::OFF_STATUS);
    wire wr_sticky = wr_go && (wr_addr_reg == pwr_pkg::OFF_STICKY);
    wire wr_eeload = wr_go && (wr_addr_reg == pwr_pkg::OFF_EELOAD);

    // bus write pipeline; the slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // sticky scratch, survives everything but global and power-on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sticky_reg <= pwr_pkg::STICKY_RST;
        else if (rst_sticky)
            sticky_reg <= pwr_pkg::STICKY_RST;
        else
            sticky_reg <= (sticky_reg & ~(wr_sticky ? wd[7:0] : 8'h00))
                          | {7'h00, send_aspm_nak};
    end

    // eeprom-loadable bits and power state, spared by hot and soft reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            eeload_reg    <= pwr_pkg::EELOAD_RST;
            br_dstate_reg <= pwr_pkg::PS_D0;
            fw_dstate_reg <= pwr_pkg::PS_D0;
            phyr_reg      <= 1'b0;
            l0s_lat_reg   <= pwr_pkg::L0S_EXIT_LAT_RST;
            l1_lat_reg    <= pwr_pkg::L1_EXIT_LAT_RST;
            ee_cnt_reg    <= 8'h00;
        end
        else if (rst_eeload)
        begin
            eeload_reg    <= pwr_pkg::EELOAD_RST;
            br_dstate_reg <= pwr_pkg::PS_D0;
            fw_dstate_reg <= pwr_pkg::PS_D0;
            phyr_reg      <= 1'b0;
            l0s_lat_reg   <= pwr_pkg::L0S_EXIT_LAT_RST;
            l1_lat_reg    <= pwr_pkg::L1_EXIT_LAT_RST;
            ee_cnt_reg    <= 8'h00;
        end
        else
        begin
            if (perst_rise)
                ee_cnt_reg <= 8'(pwr_pkg::EE_LOAD_CYC);
            else if (ee_cnt_reg != 8'h00)
                ee_cnt_reg <= ee_cnt_reg - 8'h01;
            if (wr_eeload)
                eeload_reg <= eeload_reg | wd[7:0];
            if (wr_br)
                br_dstate_reg <= wd[1:0];
            if (wr_fw)
                fw_dstate_reg <= wd[1:0];
            if (wr_fw)
                phyr_reg <= wd[pwr_pkg::FW_PHYR_BIT];
        end
    end

    // ordinary bits, cleared by every reset class
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            as_sel_reg   <= pwr_pkg::AS_OFF;
            fw_bridge_soft_reset_bit_reg  <= 1'b0;
            fw_init_reg  <= 1'b0;
            nak_flag_reg <= 1'b0;
        end
        else if (rst_ordinary)
        begin
            as_sel_reg   <= pwr_pkg::AS_OFF;
            fw_bridge_soft_reset_bit_reg  <= 1'b0;
            fw_init_reg  <= 1'b0;
            nak_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_lctl)
                as_sel_reg <= wd[1:0];
            if (wr_fw)
                fw_bridge_soft_reset_bit_reg <= wd[pwr_pkg::FW_BRIDGE_SOFT_RESET_BIT_BIT];
            if (wr_fw)
                fw_init_reg <= wd[pwr_pkg::FW_INIT_BIT];
            else if (d3cold_reg)
                fw_init_reg <= 1'b0;
            // nak seen flag, set wins over clear
            nak_flag_reg <= send_aspm_nak
                            || (nak_flag_reg && !(wr_status && wd[8]));
        end
    end

    // bridge soft reset bit clears itself the cycle after it is set, or on eeprom-class reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            br_bridge_soft_reset_bit_reg <= 1'b0;
        else if (rst_eeload || br_bridge_soft_reset_bit_reg)
            br_bridge_soft_reset_bit_reg <= 1'b0;
        else if (wr_br)
            br_bridge_soft_reset_bit_reg <= wd[pwr_pkg::BR_BRIDGE_SOFT_RESET_BIT_BIT];
    end

    // d3cold tracking: aux loss in D3 latches until fundamental reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            d3cold_reg <= 1'b0;
        else if (rst_eeload)
            d3cold_reg <= 1'b0;
        else if (aux_power_lost && fw_dstate_reg == pwr_pkg::PS_D3)
            d3cold_reg <= 1'b1;
    end

    // link power manager
    pwr_pkg::link_state_e ls_reg;
    pwr_pkg::link_state_e ls_next;
    logic [15:0] idle_cnt_reg;
    wire low_power  = (br_dstate_reg != pwr_pkg::PS_D0);
    wire l1_allowed = as_sel_reg[1] && !tx_pending && tx_idle;
    wire idle_now   = !tx_pending && tx_idle;
    wire l0s_ok     = as_sel_reg[0] && idle_now && (idle_cnt_reg >= 16'(L0S_IDLE));
    wire l1_ok      = as_sel_reg[1] && idle_now && (idle_cnt_reg >= 16'(L1_IDLE));

    // idle timer restarts on any activity
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            idle_cnt_reg <= 16'h0000;
        else if (rst_ordinary || !idle_now)
            idle_cnt_reg <= 16'h0000;
        else if (idle_cnt_reg != 16'hFFFF)
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end

    // next link state
    always_comb
    begin
        ls_next = ls_reg;
        case (ls_reg)
            pwr_pkg::LS_L0:
            begin
                if (low_power && br_dstate_reg == pwr_pkg::PS_D3)
                    ls_next = pwr_pkg::LS_L23;
                else if (low_power)
                    ls_next = pwr_pkg::LS_L1;
                else if (l1_ok)
                    ls_next = pwr_pkg::LS_ASPM_L1;
                else if (l0s_ok)
                    ls_next = pwr_pkg::LS_L0S;
            end
            pwr_pkg::LS_L0S, pwr_pkg::LS_ASPM_L1:
            begin
                // with both enabled, L0s deepens to L1 once the longer timer runs out
                if (!idle_now || low_power)
                    ls_next = pwr_pkg::LS_L0;
                else if (ls_reg == pwr_pkg::LS_L0S && l1_ok)
                    ls_next = pwr_pkg::LS_ASPM_L1;
            end
            pwr_pkg::LS_L1:
            begin
                if (br_dstate_reg == pwr_pkg::PS_D3)
                    ls_next = pwr_pkg::LS_L23;
                else if (!low_power)
                    ls_next = pwr_pkg::LS_L0;
            end
            pwr_pkg::LS_L23:
            begin
                if (!low_power)
                    ls_next = pwr_pkg::LS_L0;
            end
            default: ls_next = pwr_pkg::LS_L0;
        endcase
    end

    // clock gates, resets and events, all registered
    wire fw_d2d3    = fw_dstate_reg[1];
    wire link_rst_req = (fw_d2d3 || fw_bridge_soft_reset_bit_reg);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ls_reg            <= pwr_pkg::LS_L0;
            link_state        <= 3'(pwr_pkg::LS_L0);
            send_aspm_nak     <= 1'b0;
            bridge_clk_en     <= 1'b1;
            lc_clk_en         <= 1'b1;
            dma_link_reset    <= 1'b1;
            phy_reset         <= 1'b1;
            cfg_reset         <= 1'b1;
            eeprom_load_start <= 1'b0;
            pme_out           <= 1'b0;
        end
        else
        begin
            ls_reg <= rst_ordinary ? pwr_pkg::LS_L0 : ls_next;
            link_state <= rst_ordinary ? 3'(pwr_pkg::LS_L0) : 3'(ls_next);
            send_aspm_nak <= l1_request_rx && !l1_allowed && !rst_ordinary;
            bridge_clk_en <= (br_dstate_reg == pwr_pkg::PS_D0)
                             && (ls_next != pwr_pkg::LS_L1) && (ls_next != pwr_pkg::LS_L23);
            lc_clk_en <= (fw_dstate_reg != pwr_pkg::PS_D3);
            dma_link_reset <= link_rst_req || rst_ordinary;
            phy_reset <= phyr_reg || rst_eeload;
            cfg_reset <= rst_ordinary;
            eeprom_load_start <= perst_rise;
            pme_out <= pme_request && !d3cold_reg && !rst_ordinary;
        end
    end

    // read mux
    wire [31:0] rd_status = {20'h00000, 3'h0, nak_flag_reg, d3cold_reg,
                             (ee_cnt_reg != 8'h00), fw_init_reg, 2'h0, ls_reg};
    wire [31:0] rd_cap = {14'h0000, l1_lat_reg, l0s_lat_reg, 12'h000};
    wire [31:0] rd_mux =
        (haddr == pwr_pkg::OFF_BRIDGE_PMCSR) ? {29'h0, br_bridge_soft_reset_bit_reg, br_dstate_reg} :
        (haddr == pwr_pkg::OFF_LINK_CTRL)    ? {30'h0, as_sel_reg} :
        (haddr == pwr_pkg::OFF_LINK_CAP)     ? rd_cap :
        (haddr == pwr_pkg::OFF_FW_PMCSR)     ? {27'h0, fw_init_reg, phyr_reg, fw_bridge_soft_reset_bit_reg,
                                                fw_dstate_reg} :
        (haddr == pwr_pkg::OFF_STATUS)       ? rd_status :
        (haddr == pwr_pkg::OFF_STICKY)       ? {24'h0, sticky_reg} :
        (haddr == pwr_pkg::OFF_EELOAD)       ? {24'h0, eeload_reg} : 32'h00000000;

    // read data registered at the address phase; hready always high, OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
        end
    end
endmodule

/* File: test/power_state_reset_control_assertions.sv */
`timescale 1ns/1ps
module power_state_reset_control_checker #(
    parameter int L0S_IDLE = 4,
    parameter int L1_IDLE  = 8
) (
    // clock and reset pins
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       fundamental_reset_n,
    input wire logic       hot_reset,
    // link activity
    input wire logic       tx_pending,
    input wire logic       tx_idle,
    input wire logic       l1_request_rx,
    input wire logic       pme_request,
    // controls watched
    input wire logic [2:0] link_state,
    input wire logic       send_aspm_nak,
    input wire logic       bridge_clk_en,
    input wire logic       dma_link_reset,
    input wire logic       phy_reset,
    input wire logic       cfg_reset,
    input wire logic       eeprom_load_start,
    input wire logic       pme_out
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // an l1 request that arrives while traffic is still moving
    sequence s_busy_l1_req;
        l1_request_rx && (tx_pending || !tx_idle);
    endsequence
    // fundamental reset held long enough to pass the pin synchroniser
    sequence s_fund_held;
        !fundamental_reset_n [*4];
    endsequence

    chk_nak_busy: assert property (s_busy_l1_req |=> send_aspm_nak)
        else $error("refused l1 request got no nak");
    chk_nak_cause: assert property (send_aspm_nak |-> $past(l1_request_rx))
        else $error("nak sent without an l1 request");
    chk_fund_reset: assert property (s_fund_held |-> cfg_reset && phy_reset && dma_link_reset)
        else $error("fundamental reset did not reach every class");
    chk_hot_cfg: assert property (hot_reset [*4] |-> cfg_reset)
        else $error("hot reset did not reset configuration");
    chk_ee_pulse: assert property (eeprom_load_start |=> !eeprom_load_start)
        else $error("eeprom start longer than one cycle");
    chk_ee_cause: assert property (eeprom_load_start |-> $past(fundamental_reset_n, 2))
        else $error("eeprom start while fundamental reset held");
    chk_clk_gate: assert property ((link_state == 3'h2 || link_state == 3'h4) |-> !bridge_clk_en)
        else $error("bridge clock running in low power state");
    chk_aspm_idle: assert property (
        ((link_state == 3'h1 || link_state == 3'h3) && $past(link_state) == 3'h0)
        |-> $past(tx_idle) && !$past(tx_pending))
        else $error("active state entry while traffic pending");
    chk_pme_cause: assert property (pme_out |-> $past(pme_request))
        else $error("pme raised without a request");
endmodule

bind power_state_reset_control power_state_reset_control_checker #(
    .L0S_IDLE(L0S_IDLE),
    .L1_IDLE(L1_IDLE)
) u_chk (
    .hclk(hclk), .hresetn(hresetn), .fundamental_reset_n(fundamental_reset_n),
    .hot_reset(hot_reset), .tx_pending(tx_pending), .tx_idle(tx_idle),
    .l1_request_rx(l1_request_rx), .pme_request(pme_request), .link_state(link_state),
    .send_aspm_nak(send_aspm_nak), .bridge_clk_en(bridge_clk_en),
    .dma_link_reset(dma_link_reset), .phy_reset(phy_reset), .cfg_reset(cfg_reset),
    .eeprom_load_start(eeprom_load_start), .pme_out(pme_out)
);

/* File: test/pcie_link_partner.sv */
`timescale 1ns/1ps
module pcie_link_partner (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // command from the bench
    input wire logic       req_l1,
    // link side
    input wire logic [2:0] link_state,
    input wire logic       send_aspm_nak,
    output logic           l1_request_rx,
    output logic           pcie_reference_clock_in_on,
    output logic     [7:0] nak_cnt
);
    logic nak_d;

    // reference clock kept
    // stopped only once the link sits in L2/L3
    assign pcie_reference_clock_in_on = (link_state != pwr_pkg::LS_L23);

    // a request dllp lasts one cycle; naks counted on their rising edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            l1_request_rx <= 1'b0;
            nak_d         <= 1'b0;
            nak_cnt       <= 8'h00;
        end
        else
        begin
            l1_request_rx <= req_l1;
            nak_d         <= send_aspm_nak;
            if (send_aspm_nak && !nak_d)
                nak_cnt <= nak_cnt + 8'h01;
        end
    end
endmodule

/* File: test/power_state_reset_control_bench.sv */
`timescale 1ns/1ps
module power_state_reset_control_bench;
    logic        hclk, hresetn, global_reset_input_n, fundamental_reset_n, hot_reset;
    logic        hsel, hwrite, tx_pending, tx_idle, aux_power_lost, pme_request, req_l1;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, link_state;
    logic [31:0] hwdata, hrdata, rd;
    logic        hreadyout, hresp, send_aspm_nak, bridge_clk_en, lc_clk_en, pme_out;
    logic        dma_link_reset, phy_reset, cfg_reset, eeprom_load_start, l1_request_rx;
    logic        pcie_reference_clock_in_on;
    logic [7:0]  nak_cnt;
    int          errors, n_checks, cyc;

    // short idle counts keep the run brief
    power_state_reset_control #(.L0S_IDLE(4), .L1_IDLE(8)) dut (
        .hclk(hclk), .hresetn(hresetn), .global_reset_input_n(global_reset_input_n),
        .fundamental_reset_n(fundamental_reset_n), .hot_reset(hot_reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tx_pending(tx_pending), .tx_idle(tx_idle), .l1_request_rx(l1_request_rx),
        .aux_power_lost(aux_power_lost), .pme_request(pme_request),
        .link_state(link_state), .send_aspm_nak(send_aspm_nak),
        .bridge_clk_en(bridge_clk_en), .lc_clk_en(lc_clk_en),
        .dma_link_reset(dma_link_reset), .phy_reset(phy_reset), .cfg_reset(cfg_reset),
        .eeprom_load_start(eeprom_load_start), .pme_out(pme_out));

    pcie_link_partner partner (
        .hclk(hclk), .hresetn(hresetn), .req_l1(req_l1), .link_state(link_state),
        .send_aspm_nak(send_aspm_nak), .l1_request_rx(l1_request_rx),
        .pcie_reference_clock_in_on(pcie_reference_clock_in_on), .nak_cnt(nak_cnt));

    // 200 MHz clock and a hang guard
    always #2.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // address phase held until hready, then data phase until hready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_ls(input logic [2:0] e);
        for (int i = 0; i < 60 && link_state !== e; i++)
            @(posedge hclk);
        chk({29'h0, link_state}, {29'h0, e});
    endtask

    task automatic t_reset_values();
        rdc(pwr_pkg::OFF_LINK_CAP, {14'h0, pwr_pkg::L1_EXIT_LAT_RST, pwr_pkg::L0S_EXIT_LAT_RST, 12'h0});
        rdc(pwr_pkg::OFF_LINK_CTRL, 32'h0);
        rdc(pwr_pkg::OFF_EELOAD, {24'h0, pwr_pkg::EELOAD_RST});
        rdc(8'h3C, 32'h0);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // each entry mode, then traffic pulls the link back to L0
    task automatic t_aspm();
        logic [1:0] m[4] = '{pwr_pkg::AS_OFF, pwr_pkg::AS_L0S, pwr_pkg::AS_L1, pwr_pkg::AS_BOTH};
        logic [2:0] e[4] = '{3'h0, 3'h1, 3'h3, 3'h3};
        for (int i = 0; i < 4; i++)
        begin
            bus(pwr_pkg::OFF_LINK_CTRL, 1'b1, {30'h0, m[i]});
            tx_idle <= 1'b1;
            tx_pending <= 1'b0;
            cycles(12);
            wait_ls(e[i]);
            tx_idle <= 1'b0;
            tx_pending <= 1'b1;
            wait_ls(3'h0);
        end
    endtask

    task automatic l1_req(input logic [7:0] exp);
        req_l1 <= 1'b1;
        @(posedge hclk);
        req_l1 <= 1'b0;
        cycles(4);
        chk({24'h0, nak_cnt}, {24'h0, exp});
    endtask

    task automatic t_nak();
        bus(pwr_pkg::OFF_LINK_CTRL, 1'b1, {30'h0, pwr_pkg::AS_L0S});
        tx_idle <= 1'b1;
        tx_pending <= 1'b0;
        l1_req(8'h01);
        rdc(pwr_pkg::OFF_STICKY, 32'h1);
        bus(pwr_pkg::OFF_STICKY, 1'b1, 32'h0);
        rdc(pwr_pkg::OFF_STICKY, 32'h1);
        bus(pwr_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk({31'h0, rd[8]}, 32'h1);
        bus(pwr_pkg::OFF_STATUS, 1'b1, 32'h100);
        bus(pwr_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk({31'h0, rd[8]}, 32'h0);
        bus(pwr_pkg::OFF_LINK_CTRL, 1'b1, {30'h0, pwr_pkg::AS_L1});
        cycles(12);
        l1_req(8'h01);
        tx_pending <= 1'b1;
        l1_req(8'h02);
        tx_pending <= 1'b0;
    endtask

    task automatic t_eeload();
        bus(pwr_pkg::OFF_EELOAD, 1'b1, 32'h5);
        rdc(pwr_pkg::OFF_EELOAD, 32'h5);
        bus(pwr_pkg::OFF_EELOAD, 1'b1, 32'h2);
        rdc(pwr_pkg::OFF_EELOAD, 32'h7);
        bus(pwr_pkg::OFF_EELOAD, 1'b1, 32'h0);
        rdc(pwr_pkg::OFF_EELOAD, 32'h7);
    endtask

    task automatic t_resets();
        hot_reset <= 1'b1;
        cycles(6);
        chk({31'h0, cfg_reset}, 32'h1);
        hot_reset <= 1'b0;
        cycles(8);
        rdc(pwr_pkg::OFF_LINK_CTRL, 32'h0);
        rdc(pwr_pkg::OFF_EELOAD, 32'h7);
        rdc(pwr_pkg::OFF_STICKY, 32'h1);
        bus(pwr_pkg::OFF_LINK_CTRL, 1'b1, 32'h3);
        bus(pwr_pkg::OFF_BRIDGE_PMCSR, 1'b1, 32'h1 << pwr_pkg::BR_BRIDGE_SOFT_RESET_BIT_BIT);
        cycles(4);
        rdc(pwr_pkg::OFF_LINK_CTRL, 32'h0);
        fundamental_reset_n <= 1'b0;
        cycles(6);
        chk({29'h0, phy_reset, dma_link_reset, cfg_reset}, 32'h7);
        fundamental_reset_n <= 1'b1;
        for (int i = 0; i < 10 && eeprom_load_start !== 1'b1; i++)
            @(posedge hclk);
        chk({31'h0, eeprom_load_start}, 32'h1);
        cycles(80);
        rdc(pwr_pkg::OFF_EELOAD, {24'h0, pwr_pkg::EELOAD_RST});
        rdc(pwr_pkg::OFF_STICKY, 32'h1);
        global_reset_input_n <= 1'b0;
        cycles(6);
        global_reset_input_n <= 1'b1;
        cycles(80);
        rdc(pwr_pkg::OFF_STICKY, {24'h0, pwr_pkg::STICKY_RST});
    endtask

    // controller power states; writes reinitialise it after the full reset
    task automatic fw(input logic [31:0] v, input logic [2:0] exp);
        bus(pwr_pkg::OFF_FW_PMCSR, 1'b1, v);
        cycles(4);
        chk({29'h0, dma_link_reset, phy_reset, lc_clk_en}, {29'h0, exp});
    endtask

    task automatic t_controller();
        fw(32'h10, 3'b001);
        rdc(pwr_pkg::OFF_FW_PMCSR, 32'h10);
        pme_request <= 1'b1;
        cycles(2);
        chk({31'h0, pme_out}, 32'h1);
        fw(32'h12, 3'b101);
        fw(32'h14, 3'b101);
        fw(32'h18, 3'b011);
        fw(32'h13, 3'b100);
        aux_power_lost <= 1'b1;
        cycles(3);
        chk({31'h0, pme_out}, 32'h0);
        aux_power_lost <= 1'b0;
        pme_request <= 1'b0;
        fw(32'h10, 3'b001);
    endtask

    task automatic t_dstate();
        chk({31'h0, bridge_clk_en}, 32'h1);
        bus(pwr_pkg::OFF_BRIDGE_PMCSR, 1'b1, {30'h0, pwr_pkg::PS_D1});
        wait_ls(pwr_pkg::LS_L1);
        chk({31'h0, bridge_clk_en}, 32'h0);
        bus(pwr_pkg::OFF_BRIDGE_PMCSR, 1'b1, {30'h0, pwr_pkg::PS_D3});
        wait_ls(pwr_pkg::LS_L23);
        chk({31'h0, pcie_reference_clock_in_on}, 32'h0);
    endtask

    initial
    begin
        {hclk, hsel, hwrite, hot_reset, tx_pending, tx_idle} = '0;
        {aux_power_lost, pme_request, req_l1, hresetn} = '0;
        {global_reset_input_n, fundamental_reset_n} = 2'b11;
        {haddr, htrans, hwdata, hsize} = {8'h00, 2'h0, 32'h0, 3'h2};
        cycles(16);
        hresetn <= 1'b1;
        cycles(80);
        t_reset_values();
        t_aspm();
        t_nak();
        t_eeload();
        t_resets();
        t_controller();
        t_dstate();
        finish_test();
    end
endmodule
